// ===== analog_front_model.sv
// Converter stand-in answering each conversion start
`timescale 1ns/100ps
`default_nettype none
module analog_front_model
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Handshake
	input wire logic slow,
	input wire logic convert_start,
	output logic conversion_acquired
);
	int unsigned wait_cnt;
	// Acquire takes 2 or 6 cycles, slow stresses settling
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			wait_cnt <= 0;
			conversion_acquired <= 1'h0;
		end
		else
		begin
			conversion_acquired <= (wait_cnt == 1);
			if (convert_start)
				wait_cnt <= slow ? 6 : 2;
			else if (wait_cnt != 0)
				wait_cnt <= wait_cnt - 1;
		end
	end
endmodule
`default_nettype wire

// ===== cfg_memory.sv
// Channel configuration memory, one write port, one registered read
`timescale 1ns/100ps
`default_nettype none
`include "scan_seq_params.svh"
module cfg_memory
#(
	parameter int DEPTH = `CFG_DEPTH,
	parameter int ADDR_W = `CFG_ADDR_W
)
(
	// Clock
	input wire logic ref_clk,
	// Host write port
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire scan_seq_pkg::cfg_word_type wr_data,
	// Read port, data valid one cycle after address
	input wire logic [ADDR_W-1:0] rd_addr,
	output scan_seq_pkg::cfg_word_type rd_data
);
	scan_seq_pkg::cfg_word_type mem [DEPTH];

	always_ff @(posedge ref_clk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		rd_data <= mem[rd_addr];
	end
endmodule
`default_nettype wire

// ===== edge_sync.sv
// Two-stage synchroniser with rise and fall pulses
`timescale 1ns/100ps
`default_nettype none
module edge_sync
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Asynchronous level in
	input wire logic async_in,
	// Synchronised level and edges
	output logic level,
	output logic rise,
	output logic fall
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end
		else
		begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign rise = sync_reg & ~last_reg;
	assign fall = ~sync_reg & last_reg;
endmodule
`default_nettype wire

// ===== scan_seq_params.svh
// Constants for the channel scan sequencer
`ifndef SCAN_SEQ_PARAMS_SVH
`define SCAN_SEQ_PARAMS_SVH
`define CFG_DEPTH 512
`define CFG_ADDR_W 9
`define CHAN_W 6
`define GAIN_W 3
`define FIELD_CHAN_LSB 0
`define FIELD_GAIN_LSB 6
`define FIELD_DIFF_BIT 9
`define FIELD_BIP_BIT 10
`define FIELD_SYNC_BIT 11
`define FIELD_SER_BIT 12
`define FIELD_EOS_BIT 13
`define CFG_WORD_W 14
`define SCAN_CLK_PULSE_CYC 1
`define COUNT_W 32
`define DIV_W 16
`endif

// ===== scan_seq_pkg.sv
// Types for the channel scan sequencer
`include "scan_seq_params.svh"
package scan_seq_pkg;
	typedef struct packed {
		logic end_of_sequence;
		logic serial_enable;
		logic rate_sync;
		logic bipolar;
		logic differential;
		logic [`GAIN_W-1:0] gain;
		logic [`CHAN_W-1:0] channel;
	} cfg_word_type;
	typedef struct packed {
		logic [`CHAN_W-1:0] channel;
		logic [`GAIN_W-1:0] gain;
		logic differential;
		logic bipolar;
		logic rate_sync;
		logic serial_enable;
	} front_end_type;
	typedef enum logic [1:0] {
		MODE_SINGLE,
		MODE_CONTINUOUS,
		MODE_INTERVAL
	} scan_mode_type;
endpackage

// ===== scan_sequencer.sv
// Channel scan sequencer for the analog input front end
// Contract
// - Configuration memory holds 512 words, one per scan step.
// - Each word holds channel, gain, single/differential mode and range.
// - Each word holds rate sync, serial send and end-of-sequence flags.
// - Interval scan list may hold many sequences split by end flags.
// - Selected word drives channel, gain, mode, range to the front end.
// - Location pointer advances through memory on the scan-advance signal.
// - Scan clock comes from sample timer, pulses per conversion, goes out.
// - Advance is scan clock itself or scan clock divided by N.
// - Continuous scanning wraps to list start with no idle time.
// - Sample counter ends acquisition whatever the pointer position.
// - Scan clock rises once input is acquired, every conversion.
// - Interval scan, one sequence: halt at list end, wait next interval.
// - Interval scan, many sequences: halt at each sequence end and list end.
// - First interval conversion waits for first falling scan-timer edge.
// - After a halt, resume only on rising scan-timer edge.
// - Next entry selected as soon as previous conversion has begun.
// - Sample counter decrements per conversion, stops acquisition at zero.
// - Pretrigger: counter waits for second-trigger gate; scanning continues.
`timescale 1ns/100ps
`default_nettype none
`include "scan_seq_params.svh"
module scan_sequencer
#(
	parameter int ADDR_W = `CFG_ADDR_W,
	parameter int COUNT_W = `COUNT_W,
	parameter int DIV_W = `DIV_W
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Configuration memory write port
	input wire logic cfg_wr_en,
	input wire logic [ADDR_W-1:0] cfg_wr_addr,
	input wire scan_seq_pkg::cfg_word_type cfg_wr_data,
	// Acquisition control, set before arming
	input wire scan_seq_pkg::scan_mode_type scan_mode,
	input wire logic [ADDR_W-1:0] single_addr,
	input wire logic divide_enable,
	input wire logic [DIV_W-1:0] divide_count,
	input wire logic pretrigger_mode,
	input wire logic [COUNT_W-1:0] sample_count,
	input wire logic arm,
	input wire logic software_trigger,
	input wire logic software_second_trigger,
	// Timers and pins, asynchronous
	input wire logic sample_timer_n,
	input wire logic scan_timer,
	input wire logic external_convert_n,
	input wire logic external_trigger_n,
	input wire logic second_trigger_n,
	input wire logic use_external_convert,
	// Converter status
	input wire logic conversion_acquired,
	// Front end and status outputs
	output scan_seq_pkg::front_end_type front_end,
	output logic convert_start,
	output logic scan_clock_out,
	output logic acquisition_in_progress,
	output logic acquisition_done,
	output logic [ADDR_W-1:0] location,
	output logic end_of_sequence
);
	logic st_fall, ec_fall, si_rise, si_fall, et_fall, t2_fall;
	logic conv_pulse;
	logic advance;
	logic last_entry;
	logic list_end;
	logic [ADDR_W-1:0] rd_addr;
	scan_seq_pkg::cfg_word_type entry;

	edge_sync sync_sample (.ref_clk(ref_clk), .rst(rst),
		.async_in(sample_timer_n), .level(), .rise(),
		.fall(st_fall));
	edge_sync sync_external_convert_n (.ref_clk(ref_clk), .rst(rst),
		.async_in(external_convert_n), .level(), .rise(),
		.fall(ec_fall));
	edge_sync sync_interval (.ref_clk(ref_clk), .rst(rst),
		.async_in(scan_timer), .level(), .rise(si_rise),
		.fall(si_fall));
	edge_sync sync_trigger (.ref_clk(ref_clk), .rst(rst),
		.async_in(external_trigger_n), .level(), .rise(),
		.fall(et_fall));
	edge_sync sync_second (.ref_clk(ref_clk), .rst(rst),
		.async_in(second_trigger_n), .level(), .rise(),
		.fall(t2_fall));

	cfg_memory #(.DEPTH(`CFG_DEPTH), .ADDR_W(ADDR_W)) config_store (
		.ref_clk(ref_clk),
		.wr_en(cfg_wr_en),
		.wr_addr(cfg_wr_addr),
		.wr_data(cfg_wr_data),
		.rd_addr(rd_addr),
		.rd_data(entry)
	);

	// Sequencing states
	typedef enum logic [2:0] {
		IDLE,
		WAIT_TRIGGER,
		WAIT_FIRST_FALL,
		RUNNING,
		HALTED
	} seq_state_type;
	seq_state_type state_reg;
	logic [ADDR_W-1:0] ptr_reg;
	logic [DIV_W-1:0] div_reg;
	logic [COUNT_W-1:0] count_reg;
	logic count_gate_reg;
	logic sync_flag_reg;
	logic in_acq;
	logic scanning;
	logic interval;

	assign in_acq = (state_reg == RUNNING);
	assign scanning = (scan_mode != scan_seq_pkg::MODE_SINGLE);
	assign interval = (scan_mode == scan_seq_pkg::MODE_INTERVAL);
	logic stop_now;
	assign stop_now = (state_reg == RUNNING || state_reg == HALTED) &&
		count_gate_reg && count_reg == '0;

	// conversion from timer or pin
	// Conversions are gated off outside the running state, so an external
	// convert stream cannot run ahead of the trigger.
	assign conv_pulse = in_acq &
		(use_external_convert ? ec_fall : st_fall);

	assign advance = scanning & conv_pulse &
		(!divide_enable || divide_count == DIV_W'(0) ||
		div_reg == divide_count - DIV_W'(1));

	assign last_entry = entry.end_of_sequence;
	assign list_end = (ptr_reg == ADDR_W'(`CFG_DEPTH - 1)) ||
		(last_entry && !interval);

	// Divider counts conversions per entry
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			div_reg <= '0;
		end
		else if (state_reg == IDLE || advance)
		begin
			div_reg <= '0;
		end
		else if (conv_pulse)
		begin
			div_reg <= div_reg + DIV_W'(1);
		end
	end

	// Sequencer state and pointer
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= IDLE;
			ptr_reg <= '0;
		end
		else
		begin
			unique case (state_reg)
				IDLE:
				begin
					if (arm)
					begin
						ptr_reg <= scanning ? '0 : single_addr;
						state_reg <= WAIT_TRIGGER;
					end
				end
				WAIT_TRIGGER:
				begin
					if (software_trigger || et_fall)
					begin
						state_reg <= interval ? WAIT_FIRST_FALL : RUNNING;
					end
				end
				WAIT_FIRST_FALL:
				begin
					if (si_fall)
					begin
						state_reg <= RUNNING;
					end
				end
				RUNNING:
				begin
					if (count_gate_reg && count_reg == '0)
					begin
						state_reg <= IDLE;
					end
					else if (advance)
					begin
						if (interval && (last_entry || list_end))
						begin
							state_reg <= HALTED;
							ptr_reg <= (ptr_reg ==
								ADDR_W'(`CFG_DEPTH - 1)) ?
								'0 : ptr_reg + ADDR_W'(1);
						end
						else if (list_end)
						begin
							ptr_reg <= '0;
						end
						else
						begin
							ptr_reg <= ptr_reg + ADDR_W'(1);
						end
					end
				end
				HALTED:
				begin
					if (count_gate_reg && count_reg == '0)
					begin
						state_reg <= IDLE;
					end
					else if (si_rise)
					begin
						state_reg <= RUNNING;
					end
				end
			endcase
		end
	end

	// List end in continuous mode is the entry with its end flag and the wrap
	// handled above; a list filling all 512 words wraps as well.

	// Sample counter gate
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			count_gate_reg <= 1'b0;
		end
		else if (state_reg == IDLE)
		begin
			count_gate_reg <= 1'b0;
		end
		else if (state_reg == WAIT_TRIGGER &&
			(software_trigger || et_fall))
		begin
			count_gate_reg <= !pretrigger_mode;
		end
		else if (pretrigger_mode &&
			(software_second_trigger || t2_fall))
		begin
			count_gate_reg <= 1'b1;
		end
	end

	// Posttrigger sample counter
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			count_reg <= '0;
		end
		else if (state_reg == IDLE && arm)
		begin
			count_reg <= sample_count;
		end
		else if (conv_pulse && count_gate_reg && count_reg != '0)
		begin
			count_reg <= count_reg - COUNT_W'(1);
		end
	end

	// Done flag: set on finish, cleared by next arm; set wins
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			acquisition_done <= 1'b0;
		end
		else if (stop_now)
		begin
			acquisition_done <= 1'b1;
		end
		else if (arm)
		begin
			acquisition_done <= 1'b0;
		end
	end

	// scan clock rises on acquire
	// Low on conversion start, high once the converter holds the input, so
	// the rising edge tells external muxes they may switch.
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			scan_clock_out <= 1'b1;
		end
		else if (conv_pulse)
		begin
			scan_clock_out <= 1'b0;
		end
		else if (conversion_acquired)
		begin
			scan_clock_out <= 1'b1;
		end
	end

	// Memory read address is the registered pointer, so the word is ready
	// one cycle after the pointer moves and on the front end a cycle later.
	assign rd_addr = ptr_reg;

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			front_end <= '0;
			sync_flag_reg <= 1'b0;
		end
		else
		begin
			front_end.channel <= entry.channel;
			front_end.gain <= entry.gain;
			front_end.differential <= entry.differential;
			front_end.bipolar <= entry.bipolar;
			front_end.rate_sync <= entry.rate_sync;
			front_end.serial_enable <= entry.serial_enable;
			sync_flag_reg <= entry.end_of_sequence;
		end
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			convert_start <= 1'b0;
			acquisition_in_progress <= 1'b0;
			location <= '0;
		end
		else
		begin
			convert_start <= conv_pulse;
			acquisition_in_progress <= (state_reg != IDLE) && !stop_now;
			location <= ptr_reg;
		end
	end

	assign end_of_sequence = sync_flag_reg;
endmodule
`default_nettype wire

// ===== scan_sequencer_properties.sv
// Port-level properties of the scan sequencer
`include "scan_seq_params.svh"
`timescale 1ns/100ps
`default_nettype none
module scan_sequencer_properties
#(
	parameter int ADDR_W = `CFG_ADDR_W
)
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Control seen
	input wire scan_seq_pkg::scan_mode_type scan_mode,
	input wire logic arm,
	input wire logic conversion_acquired,
	// Outputs watched
	input wire logic convert_start,
	input wire logic scan_clock_out,
	input wire logic acquisition_in_progress,
	input wire logic acquisition_done,
	input wire logic [ADDR_W-1:0] location
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence conv_begun;
		convert_start ##[0:1] !scan_clock_out;
	endsequence
	sequence acq_seen;
		$past(conversion_acquired) || $past(conversion_acquired, 2);
	endsequence
	AST_SCLK_LOW: assert property (convert_start |-> conv_begun)
		else $error("scan clock not low at conversion");
	AST_SCLK_RISE: assert property ($rose(scan_clock_out) |-> acq_seen)
		else $error("scan clock rose without acquisition");
	AST_CONV_ONE: assert property (convert_start |=> !convert_start)
		else $error("convert pulse too long");
	AST_CONV_IN_ACQ: assert property (convert_start |->
		acquisition_in_progress || $past(acquisition_in_progress))
		else $error("conversion outside acquisition");
	AST_DONE_IDLE: assert property (acquisition_done |->
		!acquisition_in_progress)
		else $error("done while running");
	AST_DONE_HOLD: assert property ($fell(acquisition_done) |->
		$past(arm) || $past(arm, 2))
		else $error("done cleared without arm");
	AST_ARM_PTR: assert property (arm && !acquisition_in_progress &&
		scan_mode != scan_seq_pkg::MODE_SINGLE |-> ##[1:2] location == '0)
		else $error("pointer not reset on arm");
	AST_PTR_STEP: assert property ($changed(location) &&
		acquisition_in_progress && $past(acquisition_in_progress) &&
		scan_mode != scan_seq_pkg::MODE_SINGLE |->
		location == $past(location) + 1'h1 || location == '0)
		else $error("pointer jumped");
	AST_SINGLE_HOLD: assert property (acquisition_in_progress &&
		scan_mode == scan_seq_pkg::MODE_SINGLE |=> $stable(location))
		else $error("pointer moved in single mode");
endmodule
bind scan_sequencer scan_sequencer_properties #(.ADDR_W(ADDR_W))
	scan_sequencer_properties_i (.ref_clk, .rst, .scan_mode, .arm,
	.conversion_acquired, .convert_start, .scan_clock_out,
	.acquisition_in_progress, .acquisition_done, .location);
`default_nettype wire

// ===== scan_sequencer_tb_top.sv
// Self-checking bench for the scan sequencer
`timescale 1ns/100ps
`default_nettype none
module scan_sequencer_tb_top;
	logic ref_clk = 1'h0, rst = 1'h1, cfg_wr_en = 1'h0, arm = 1'h0;
	logic divide_enable = 1'h0, pretrigger_mode = 1'h0, slow = 1'h1;
	logic software_trigger = 1'h0, software_second_trigger = 1'h0;
	logic sample_timer_n = 1'h1, scan_timer = 1'h1;
	logic external_trigger_n = 1'h1, prev_sclk = 1'h1;
	logic external_convert_n = 1'h1, use_external_convert = 1'h0;
	logic [8:0] location;
	logic [8:0] cfg_wr_addr = 9'h0, single_addr = 9'h0;
	logic [15:0] divide_count = 16'h0;
	logic [31:0] sample_count = 32'h0, seed = 32'h18, r;
	scan_seq_pkg::cfg_word_type cfg_wr_data = '0;
	scan_seq_pkg::cfg_word_type mem [0:4];
	scan_seq_pkg::scan_mode_type scan_mode = scan_seq_pkg::MODE_SINGLE;
	scan_seq_pkg::front_end_type front_end, exp_q [$];
	logic conversion_acquired, convert_start, scan_clock_out;
	logic acquisition_in_progress, acquisition_done, end_of_sequence;
	int err_total = 0, checks = 0, conv_cnt = 0, cnt_exp = 0;
	scan_sequencer scan_sequencer_i (.ref_clk, .rst, .cfg_wr_en,
		.cfg_wr_addr, .cfg_wr_data, .scan_mode, .single_addr,
		.divide_enable, .divide_count, .pretrigger_mode, .sample_count,
		.arm, .software_trigger, .software_second_trigger,
		.sample_timer_n, .scan_timer, .external_convert_n,
		.external_trigger_n, .second_trigger_n(1'h1),
		.use_external_convert, .conversion_acquired, .front_end,
		.convert_start, .scan_clock_out, .acquisition_in_progress,
		.acquisition_done, .location, .end_of_sequence);
	analog_front_model analog_front_model_i (.ref_clk, .rst, .slow,
		.convert_start, .conversion_acquired);
	initial
	begin
		forever #12.5 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task conclude;
		$display("mismatches %0d, checks %0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task tick(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// Note the entry that the front end must show after a conversion
	task expect_entry(input int i);
		exp_q.push_back({mem[i].channel, mem[i].gain, mem[i].differential,
			mem[i].bipolar, mem[i].rate_sync, mem[i].serial_enable});
	endtask
	task fire(input int n);
		repeat (n)
		begin
			if (use_external_convert)
				external_convert_n <= 1'h0;
			else
				sample_timer_n <= 1'h0;
			tick(5);
			external_convert_n <= 1'h1;
			sample_timer_n <= 1'h1;
			tick(5);
		end
	endtask
	task go(input scan_seq_pkg::scan_mode_type m, input int cnt, input bit ext);
		scan_mode <= m;
		sample_count <= 32'(cnt);
		tick(1);
		arm <= 1'h1;
		tick(1);
		arm <= 1'h0;
		if (ext)
			external_trigger_n <= 1'h0;
		else
			software_trigger <= 1'h1;
		tick(5);
		external_trigger_n <= 1'h1;
		software_trigger <= 1'h0;
		tick(5);
	endtask
	task fin(input int n);
		tick(12);
		cnt_exp += n;
		check(32'(acquisition_done), 32'h1);
		check(32'(acquisition_in_progress), 32'h0);
		check(32'(conv_cnt), 32'(cnt_exp));
	endtask
	// Scoreboard: next entry must be on the front end by the scan clock rise
	always @(posedge ref_clk)
	begin
		prev_sclk <= scan_clock_out;
		if (convert_start)
			conv_cnt++;
		if (scan_clock_out && !prev_sclk && !rst)
		begin
			if (exp_q.size() == 0)
				check(32'h1, 32'h0);
			else
				check(32'(front_end), 32'(exp_q.pop_front()));
		end
	end
	initial
	begin
		#2000000;
		err_total++;
		conclude();
	end
	initial
	begin
		tick(4);
		rst <= 1'h0;
		tick(1);
		// Sequence ends at entries 2 and 4
		for (int i = 0; i < 5; i++)
		begin
			r = xs();
			mem[i] = r[13:0];
			mem[i].end_of_sequence = (i == 2) || (i == 4);
			cfg_wr_en <= 1'h1;
			cfg_wr_addr <= 9'(i);
			cfg_wr_data <= mem[i];
			tick(1);
		end
		cfg_wr_en <= 1'h0;
		// Continuous wrap, then a refused extra conversion
		for (int i = 0; i < 6; i++) expect_entry((i + 1) % 3);
		go(scan_seq_pkg::MODE_CONTINUOUS, 6, 1'b0);
		fire(7);
		fin(6);
		// Divided advance, two conversions per entry
		slow <= 1'h0;
		divide_enable <= 1'h1;
		divide_count <= 16'h2;
		for (int i = 0; i < 4; i++) expect_entry((i + 1) / 2);
		go(scan_seq_pkg::MODE_CONTINUOUS, 4, 1'b0);
		fire(4);
		fin(4);
		// Single entry held
		divide_enable <= 1'h0;
		use_external_convert <= 1'h1;
		single_addr <= 9'(xs() % 5);
		tick(1);
		repeat (3) expect_entry(int'(single_addr));
		go(scan_seq_pkg::MODE_SINGLE, 3, 1'b0);
		fire(3);
		fin(3);
		use_external_convert <= 1'h0;
		// Pretrigger: counting waits for the second trigger
		pretrigger_mode <= 1'h1;
		for (int i = 0; i < 5; i++) expect_entry((i + 1) % 3);
		go(scan_seq_pkg::MODE_CONTINUOUS, 2, 1'b0);
		fire(3);
		check(32'(acquisition_in_progress), 32'h1);
		software_second_trigger <= 1'h1;
		tick(1);
		software_second_trigger <= 1'h0;
		fire(2);
		fin(5);
		// Interval: wait for interval fall, halt at sequence end
		pretrigger_mode <= 1'h0;
		for (int i = 0; i < 4; i++) expect_entry(i + 1);
		go(scan_seq_pkg::MODE_INTERVAL, 4, 1'b1);
		fire(2);
		check(32'(conv_cnt), 32'(cnt_exp));
		scan_timer <= 1'h0;
		tick(5);
		fire(5);
		check(32'(conv_cnt), 32'(cnt_exp + 3));
		scan_timer <= 1'h1;
		tick(5);
		fire(1);
		fin(4);
		check(32'(exp_q.size()), 32'h0);
		check(32'(location), 32'h4);
		check(32'(end_of_sequence), 32'h1);
		conclude();
	end
endmodule
`default_nettype wire
